// ==== shared/ptr_pkg.sv ====
// Constants and carrier types for the telemetry, identification and over-current registers
package ptr_pkg;

  // Command codes on the link
  localparam logic [7:0] CMD_TEMPERATURE = 8'h8D;
  localparam logic [7:0] CMD_SW_FREQ = 8'h95;
  localparam logic [7:0] CMD_PROTO_REV = 8'h98;
  localparam logic [7:0] CMD_MAKER_ID = 8'h99;
  localparam logic [7:0] CMD_MODEL = 8'h9A;
  localparam logic [7:0] CMD_MAKER_REV = 8'h9B;
  localparam logic [7:0] CMD_SERIAL = 8'h9E;
  localparam logic [7:0] CMD_VOUT_MIN = 8'hA4;
  localparam logic [7:0] CMD_VOUT_MAX = 8'hA5;
  localparam logic [7:0] CMD_CHIP_ID = 8'hAD;
  localparam logic [7:0] CMD_CHIP_REV = 8'hAE;
  localparam logic [7:0] CMD_AVG_OC_RESP = 8'hC4;

  // Fixed values and resets
  localparam logic [4:0] EXP_ZERO = 5'h00;
  localparam logic [7:0] PROTO_REV_VAL = 8'h33;
  localparam logic [7:0] BLOCK_COUNT = 8'h01;
  localparam logic [15:0] VOUT_MIN_VAL = 16'h0100;
  localparam logic [15:0] VOUT_MAX_VAL = 16'h0B01;
  localparam logic [7:0] AVG_OC_RESP_RST = 8'h80;
  localparam logic [7:0] ID_BYTE_RST = 8'h00;
  // Arbitrary neutral identification values
  localparam logic [7:0] CHIP_ID_VAL = 8'h5A;
  localparam logic [7:0] CHIP_REV_VAL = 8'h01;

  // Response byte fields
  localparam int ACT_MSB = 7;
  localparam int ACT_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [2:0] RETRY_LATCH = 3'h0;
  localparam logic [2:0] RETRY_HICCUP = 3'h7;
  localparam int VENDOR_AVG_OC_BIT = 7;

  // Timing: delay windows use their lower bound in microseconds
  localparam int CLK_MHZ = 40;
  localparam int HICCUP_US = 1000000;
  localparam int HICCUP_CYC = HICCUP_US * CLK_MHZ;
  localparam logic [13:0] DELAY_US_TAB [8] = '{14'd160, 14'd320, 14'd640, 14'd1280,
                                                14'd2560, 14'd5120, 14'd9600, 14'd10080};
  localparam int CNT_W = 26;

  typedef enum logic [1:0] {
    ACT_CONTINUE, ACT_CONT_UNLESS_UV, ACT_DELAY_THEN_RETRY, ACT_SHUTDOWN
  } ptr_action_t;

  typedef enum {
    OC_IDLE, OC_LIMITING, OC_OFF, OC_HICCUP
  } ptr_oc_state_t;

  // Link transaction carrier
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] data;
  } ptr_link_req_t;

endpackage : ptr_pkg

// ==== rtl/ptr_regs.sv ====
// Register set with link-clock command port and fault-response engine
`timescale 1ns/10ps
module ptr_regs #(
  parameter int HICCUP_CYCLES = ptr_pkg::HICCUP_CYC
) (
  // Core clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Link side, on the link clock
  input wire logic i_link_clk,
  input wire logic i_link_req,
  input wire logic i_link_wr,
  input wire logic i_link_block,
  input wire ptr_pkg::ptr_link_req_t i_link_cmd,
  output logic o_link_ack,
  output logic o_link_nack,
  output logic [15:0] o_link_rdata,
  // Measurements and regulator state (core clock)
  input wire logic [10:0] i_temp_c,
  input wire logic [10:0] i_freq_khz,
  input wire logic i_regulating,
  input wire logic i_avg_oc_event,
  input wire logic i_current_limiting,
  input wire logic i_output_undervoltage_event,
  input wire logic i_enable_off,
  input wire logic i_other_fault_off,
  input wire logic i_clear_faults,
  input wire logic i_store_all,
  // Status and control outputs
  output logic o_status_iout,
  output logic o_status_none_above,
  output logic [7:0] o_vendor_fault_summary_byte,
  output logic o_alert_line_n,
  output logic o_invalid_data,
  output logic o_output_enable,
  output logic [7:0] o_nv_avg_oc_cfg,
  output logic [31:0] o_nv_id_bytes,
  output logic o_nv_store_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: request toggle out, answer toggle back
  typedef struct packed {
    logic req_tgl;
    logic [2:0] ans_sync;
    ptr_pkg::ptr_link_req_t cmd;
    logic wr;
    logic block;
    logic busy;
    logic ack;
    logic nack;
    logic [15:0] rdata;
  } ptr_link_st_t;

  ptr_link_st_t lk_r, lk_nxt;
  logic ans_tgl_r;
  logic ans_ok_r;
  logic [15:0] ans_data_r;

  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.ans_sync = {lk_r.ans_sync[1:0], ans_tgl_r};
    lk_nxt.ack = 1'b0;
    lk_nxt.nack = 1'b0;
    // No new request in the answer cycle: the requester still holds the old one
    if (i_link_req && !lk_r.busy && !lk_r.ack && !lk_r.nack) begin
      lk_nxt.cmd = i_link_cmd;
      lk_nxt.wr = i_link_wr;
      lk_nxt.block = i_link_block;
      lk_nxt.busy = 1'b1;
      lk_nxt.req_tgl = ~lk_r.req_tgl;
    end
    if (lk_r.busy && (lk_r.ans_sync[2] != lk_r.ans_sync[1])) begin
      lk_nxt.busy = 1'b0;
      lk_nxt.ack = ans_ok_r;
      lk_nxt.nack = ~ans_ok_r;
      lk_nxt.rdata = ans_data_r;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!i_nrst) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  assign o_link_ack = lk_r.ack;
  assign o_link_nack = lk_r.nack;
  assign o_link_rdata = lk_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain state
  typedef struct packed {
    logic [2:0] req_sync;
    logic ans_tgl;
    logic ans_ok;
    logic [15:0] ans_data;
    logic [7:0] resp_cfg;
    logic [7:0] id_maker;
    logic [7:0] id_model;
    logic [7:0] id_rev;
    logic [7:0] id_serial;
    logic avg_oc_flag;
    logic invalid;
    ptr_pkg::ptr_oc_state_t oc_st;
    logic [ptr_pkg::CNT_W-1:0] cnt;
    logic out_en;
    logic [7:0] nv_cfg;
    logic [31:0] nv_id;
    logic nv_pulse;
  } ptr_core_st_t;

  ptr_core_st_t c_r, c_nxt;
  logic new_req;
  logic [15:0] rd;
  logic ok;
  logic [2:0] retry;
  logic [2:0] dly_code;
  ptr_pkg::ptr_action_t act;
  logic [ptr_pkg::CNT_W-1:0] dly_cyc;

  assign new_req = c_r.req_sync[2] != c_r.req_sync[1];
  assign retry = c_r.resp_cfg[ptr_pkg::RETRY_MSB:ptr_pkg::RETRY_LSB];
  assign dly_code = c_r.resp_cfg[ptr_pkg::DELAY_MSB:ptr_pkg::DELAY_LSB];
  assign act = ptr_pkg::ptr_action_t'(c_r.resp_cfg[ptr_pkg::ACT_MSB:ptr_pkg::ACT_LSB]);
  assign dly_cyc = ptr_pkg::CNT_W'(ptr_pkg::DELAY_US_TAB[dly_code] * ptr_pkg::CLK_MHZ);

  // Read decode; the command word was held stable by the link domain while busy
  always_comb begin
    rd = 16'h0000;
    ok = 1'b1;
    case (lk_r.cmd.cmd)
      // exponent zero, signed mantissa as delivered
      ptr_pkg::CMD_TEMPERATURE: rd = {ptr_pkg::EXP_ZERO, i_temp_c};
      ptr_pkg::CMD_SW_FREQ: begin
        rd = {ptr_pkg::EXP_ZERO, i_freq_khz};
        ok = i_regulating;
      end
      // revision byte fields, fixed 33 hex
      ptr_pkg::CMD_PROTO_REV: rd = {8'h00, ptr_pkg::PROTO_REV_VAL};
      // count low, value high; same format
      ptr_pkg::CMD_MAKER_ID: rd = {c_r.id_maker, ptr_pkg::BLOCK_COUNT};
      ptr_pkg::CMD_MODEL: rd = {c_r.id_model, ptr_pkg::BLOCK_COUNT};
      ptr_pkg::CMD_MAKER_REV: rd = {c_r.id_rev, ptr_pkg::BLOCK_COUNT};
      ptr_pkg::CMD_SERIAL: rd = {c_r.id_serial, ptr_pkg::BLOCK_COUNT};
      ptr_pkg::CMD_VOUT_MIN: rd = ptr_pkg::VOUT_MIN_VAL;
      ptr_pkg::CMD_VOUT_MAX: rd = ptr_pkg::VOUT_MAX_VAL;
      ptr_pkg::CMD_CHIP_ID: rd = {ptr_pkg::CHIP_ID_VAL, ptr_pkg::BLOCK_COUNT};
      ptr_pkg::CMD_CHIP_REV: rd = {ptr_pkg::CHIP_REV_VAL, ptr_pkg::BLOCK_COUNT};
      ptr_pkg::CMD_AVG_OC_RESP: rd = {8'h00, c_r.resp_cfg};
      default: ok = 1'b0;
    endcase
  end

  always_comb begin
    logic is_id;
    logic id_ok;
    logic inv_set;
    is_id = 1'b0;
    id_ok = 1'b0;
    inv_set = 1'b0;
    c_nxt = c_r;
    c_nxt.req_sync = {c_r.req_sync[1:0], lk_r.req_tgl};
    c_nxt.nv_pulse = 1'b0;
    if (new_req) begin
      is_id = (lk_r.cmd.cmd == ptr_pkg::CMD_MAKER_ID) || (lk_r.cmd.cmd == ptr_pkg::CMD_MODEL) ||
              (lk_r.cmd.cmd == ptr_pkg::CMD_MAKER_REV) || (lk_r.cmd.cmd == ptr_pkg::CMD_SERIAL);
      id_ok = is_id && lk_r.block;
      c_nxt.ans_tgl = ~c_r.ans_tgl;
      c_nxt.ans_data = rd;
      // identification words only via block transfers
      c_nxt.ans_ok = lk_r.wr ? 1'b0 : (ok && (!is_id || id_ok) &&
                     (!(lk_r.cmd.cmd == ptr_pkg::CMD_CHIP_ID ||
                        lk_r.cmd.cmd == ptr_pkg::CMD_CHIP_REV) || lk_r.block));
      if (lk_r.wr) begin
        if (id_ok && lk_r.cmd.data[7:0] == ptr_pkg::BLOCK_COUNT) begin
          c_nxt.ans_ok = 1'b1;
          case (lk_r.cmd.cmd)
            ptr_pkg::CMD_MAKER_ID: c_nxt.id_maker = lk_r.cmd.data[15:8];
            ptr_pkg::CMD_MODEL: c_nxt.id_model = lk_r.cmd.data[15:8];
            ptr_pkg::CMD_MAKER_REV: c_nxt.id_rev = lk_r.cmd.data[15:8];
            default: c_nxt.id_serial = lk_r.cmd.data[15:8];
          endcase
        end else if (lk_r.cmd.cmd == ptr_pkg::CMD_AVG_OC_RESP) begin
          c_nxt.ans_ok = 1'b1;
          // unsupported retry code flagged, value kept
          if (lk_r.cmd.data[5:3] != ptr_pkg::RETRY_LATCH &&
              lk_r.cmd.data[5:3] != ptr_pkg::RETRY_HICCUP) begin
            c_nxt.invalid = 1'b1;
            inv_set = 1'b1;
          end else begin
            c_nxt.resp_cfg = lk_r.cmd.data[7:0];
          end
        end
      end
    end
    // store-all snapshots high bytes; response byte storable
    if (i_store_all) begin
      c_nxt.nv_id = {c_r.id_maker, c_r.id_model, c_r.id_rev, c_r.id_serial};
      c_nxt.nv_cfg = c_r.resp_cfg;
      c_nxt.nv_pulse = 1'b1;
    end
    // sticky flags, set wins over clear
    if (i_clear_faults) begin
      c_nxt.avg_oc_flag = 1'b0;
      c_nxt.invalid = 1'b0;
    end
    // A bad write in the clearing cycle still leaves the flag set
    if (inv_set) c_nxt.invalid = 1'b1;
    if (i_avg_oc_event) c_nxt.avg_oc_flag = 1'b1;
    if (c_r.cnt != '0) c_nxt.cnt = c_r.cnt - 1'b1;
    case (c_r.oc_st)
      ptr_pkg::OC_IDLE: begin
        if (i_avg_oc_event) begin
          case (act)
            ptr_pkg::ACT_CONTINUE: c_nxt.oc_st = ptr_pkg::OC_IDLE;
            ptr_pkg::ACT_CONT_UNLESS_UV: c_nxt.oc_st = ptr_pkg::OC_LIMITING;
            ptr_pkg::ACT_DELAY_THEN_RETRY: begin
              c_nxt.oc_st = ptr_pkg::OC_LIMITING;
              c_nxt.cnt = dly_cyc;
            end
            default: c_nxt.oc_st = ptr_pkg::OC_OFF;
          endcase
        end
      end
      ptr_pkg::OC_LIMITING: begin
        if (act == ptr_pkg::ACT_CONT_UNLESS_UV) begin
          if (i_output_undervoltage_event) c_nxt.oc_st = ptr_pkg::OC_OFF;
        end else if (!i_current_limiting) begin
          c_nxt.oc_st = ptr_pkg::OC_IDLE;
        end else if (c_r.cnt == '0) begin
          c_nxt.oc_st = ptr_pkg::OC_OFF;
        end
      end
      ptr_pkg::OC_OFF: begin
        c_nxt.out_en = 1'b0;
        // hiccup wait; latch off until cleared
        if (retry == ptr_pkg::RETRY_HICCUP && !i_enable_off && !i_other_fault_off) begin
          c_nxt.oc_st = ptr_pkg::OC_HICCUP;
          c_nxt.cnt = ptr_pkg::CNT_W'(HICCUP_CYCLES);
        end else if (i_clear_faults && retry == ptr_pkg::RETRY_LATCH) begin
          c_nxt.oc_st = ptr_pkg::OC_IDLE;
          c_nxt.out_en = 1'b1;
        end
      end
      ptr_pkg::OC_HICCUP: begin
        if (i_enable_off || i_other_fault_off) begin
          c_nxt.oc_st = ptr_pkg::OC_OFF;
        end else if (c_r.cnt == '0) begin
          c_nxt.oc_st = ptr_pkg::OC_IDLE;
          c_nxt.out_en = 1'b1;
        end
      end
      default: c_nxt.oc_st = ptr_pkg::OC_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      c_r <= '0;
      c_r.resp_cfg <= ptr_pkg::AVG_OC_RESP_RST;
      c_r.id_maker <= ptr_pkg::ID_BYTE_RST;
      c_r.oc_st <= ptr_pkg::OC_IDLE;
      c_r.out_en <= 1'b1;
      c_r.nv_cfg <= ptr_pkg::AVG_OC_RESP_RST;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign ans_tgl_r = c_r.ans_tgl;
  assign ans_ok_r = c_r.ans_ok;
  assign ans_data_r = c_r.ans_data;
  assign o_status_iout = c_r.avg_oc_flag;
  assign o_status_none_above = c_r.avg_oc_flag;
  assign o_vendor_fault_summary_byte = {c_r.avg_oc_flag, 7'h00};
  assign o_alert_line_n = ~(c_r.avg_oc_flag | c_r.invalid);
  assign o_invalid_data = c_r.invalid;
  assign o_output_enable = c_r.out_en;
  assign o_nv_avg_oc_cfg = c_r.nv_cfg;
  assign o_nv_id_bytes = c_r.nv_id;
  assign o_nv_store_pulse = c_r.nv_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // flag drives alert low
  alert_follows_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_avg_oc_event |=> !o_alert_line_n && o_vendor_fault_summary_byte[7])
    else $error("alert not raised on fault");
  flag_sticky_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_status_iout && !i_clear_faults |=> o_status_iout)
    else $error("fault flag dropped");
  bad_retry_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    new_req && lk_r.wr && lk_r.cmd.cmd == ptr_pkg::CMD_AVG_OC_RESP &&
    lk_r.cmd.data[5:3] inside {[3'h1:3'h6]} |=> o_invalid_data && $stable(c_r.resp_cfg))
    else $error("unsupported retry accepted");
  latch_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    c_r.oc_st == ptr_pkg::OC_OFF && retry == ptr_pkg::RETRY_LATCH && !i_clear_faults
    |=> !o_output_enable)
    else $error("output restarted while latched");
  freq_ack_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    new_req && !lk_r.wr && lk_r.cmd.cmd == ptr_pkg::CMD_SW_FREQ
    |=> c_r.ans_ok == $past(i_regulating))
    else $error("frequency ack while not regulating");
  rev_value_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    new_req && lk_r.cmd.cmd == ptr_pkg::CMD_PROTO_REV |=> c_r.ans_data == 16'h0033)
    else $error("revision byte wrong");
  vmin_value_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    new_req && lk_r.cmd.cmd == ptr_pkg::CMD_VOUT_MIN |=> c_r.ans_data == 16'h0100)
    else $error("rated minimum wrong");
  vmax_value_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    new_req && lk_r.cmd.cmd == ptr_pkg::CMD_VOUT_MAX |=> c_r.ans_data == 16'h0B01)
    else $error("rated maximum wrong");
  store_ids_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_store_all |=> o_nv_store_pulse && o_nv_id_bytes[31:24] == $past(c_r.id_maker))
    else $error("store did not capture ids");
  id_format_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    new_req && lk_r.cmd.cmd == ptr_pkg::CMD_MAKER_ID |=> c_r.ans_data[7:0] == 8'h01)
    else $error("count byte not one");
  shutdown_act_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    c_r.oc_st == ptr_pkg::OC_IDLE && i_avg_oc_event && act == ptr_pkg::ACT_SHUTDOWN
    |=> c_r.oc_st == ptr_pkg::OC_OFF)
    else $error("shutdown action not taken");
  hiccup_stop_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    c_r.oc_st == ptr_pkg::OC_HICCUP && (i_enable_off || i_other_fault_off)
    |=> c_r.oc_st == ptr_pkg::OC_OFF && !o_output_enable)
    else $error("hiccup kept running while commanded off");
  cov_fault_c: cover property (@(posedge i_ref_clk) i_avg_oc_event ##1 !o_alert_line_n);
  cov_hiccup_c: cover property (@(posedge i_ref_clk) c_r.oc_st == ptr_pkg::OC_HICCUP);
  cov_write_c: cover property (@(posedge i_ref_clk) new_req && lk_r.wr);
  cov_latch_c: cover property (@(posedge i_ref_clk)
    c_r.oc_st == ptr_pkg::OC_OFF && retry == ptr_pkg::RETRY_LATCH);
  cov_invalid_c: cover property (@(posedge i_ref_clk) $rose(o_invalid_data));

endmodule // ptr_regs

// ==== verification/ptr_host_model.sv ====
// Host link controller model driving the register set's command port
`timescale 1ns/10ps
module ptr_host_model (
  // Link clock
  input wire logic i_link_clk,
  // Answer from the register set
  input wire logic i_link_ack,
  input wire logic i_link_nack,
  input wire logic [15:0] i_link_rdata,
  // Request towards the register set
  output logic o_link_req,
  output logic o_link_wr,
  output logic o_link_block,
  output ptr_pkg::ptr_link_req_t o_link_cmd
);
  initial begin
    o_link_req = 1'b0;
    o_link_wr = 1'b0;
    o_link_block = 1'b0;
    o_link_cmd = '0;
  end
  function automatic logic [15:0] blk_word(input logic [7:0] v);
    return {v, ptr_pkg::BLOCK_COUNT};
  endfunction
  // One transfer; resp bit 0 is ack, bit 1 is nack, zero means no answer
  task automatic xfer(input logic wr, input logic blk, input ptr_pkg::ptr_link_req_t c,
                      output logic [1:0] resp, output logic [15:0] rd);
    int n;
    @(posedge i_link_clk);
    #1;
    o_link_req = 1'b1;
    o_link_wr = wr;
    o_link_block = blk;
    o_link_cmd = c;
    n = 0;
    do begin
      @(posedge i_link_clk);
      n++;
    end while (i_link_ack !== 1'b1 && i_link_nack !== 1'b1 && n < 64);
    resp = {i_link_nack === 1'b1, i_link_ack === 1'b1};
    rd = i_link_rdata;
    #1;
    // Released lines show the inverse of the last value
    o_link_req = 1'b0;
    o_link_wr = ~wr;
    o_link_block = ~blk;
    o_link_cmd = ~c;
  endtask
endmodule // ptr_host_model

// ==== verification/test_ptr_regs.sv ====
// Self-checking bench for the register set with a host link model
`timescale 1ns/10ps
module test_ptr_regs;
  logic i_ref_clk, i_nrst, i_link_clk, i_link_req, i_link_wr, i_link_block;
  ptr_pkg::ptr_link_req_t i_link_cmd;
  logic o_link_ack, o_link_nack, i_regulating, i_avg_oc_event, i_current_limiting;
  logic [15:0] o_link_rdata, rdat;
  logic [10:0] i_temp_c, i_freq_khz;
  logic i_output_undervoltage_event, i_enable_off, i_clear_faults, i_store_all, i_other_fault_off;
  logic o_status_iout, o_status_none_above, o_alert_line_n, o_invalid_data;
  logic o_output_enable, o_nv_store_pulse;
  logic [7:0] o_vendor_fault_summary_byte, o_nv_avg_oc_cfg;
  logic [31:0] o_nv_id_bytes;
  logic [1:0] resp;
  logic [7:0] v [4];
  logic [7:0] ids [4];
  int checks, n_mismatch, cyc, seed, i, t, code;
  localparam int CYC_MAX = 30000;
  ptr_regs #(.HICCUP_CYCLES(200)) i_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_link_clk(i_link_clk), .i_link_req(i_link_req), .i_link_wr(i_link_wr),
    .i_link_block(i_link_block), .i_link_cmd(i_link_cmd), .o_link_ack(o_link_ack),
    .o_link_nack(o_link_nack), .o_link_rdata(o_link_rdata), .i_temp_c(i_temp_c),
    .i_freq_khz(i_freq_khz), .i_regulating(i_regulating), .i_avg_oc_event(i_avg_oc_event),
    .i_current_limiting(i_current_limiting),
    .i_output_undervoltage_event(i_output_undervoltage_event), .i_enable_off(i_enable_off),
    .i_other_fault_off(i_other_fault_off), .i_clear_faults(i_clear_faults),
    .i_store_all(i_store_all),
    .o_status_iout(o_status_iout), .o_status_none_above(o_status_none_above),
    .o_vendor_fault_summary_byte(o_vendor_fault_summary_byte),
    .o_alert_line_n(o_alert_line_n), .o_invalid_data(o_invalid_data),
    .o_output_enable(o_output_enable), .o_nv_avg_oc_cfg(o_nv_avg_oc_cfg),
    .o_nv_id_bytes(o_nv_id_bytes), .o_nv_store_pulse(o_nv_store_pulse));
  ptr_host_model i_host (.i_link_clk(i_link_clk), .i_link_ack(o_link_ack),
    .i_link_nack(o_link_nack), .i_link_rdata(o_link_rdata), .o_link_req(i_link_req),
    .o_link_wr(i_link_wr), .o_link_block(i_link_block), .o_link_cmd(i_link_cmd));
  ////////////////////////////////////////////////////////////////////////////////
  initial i_ref_clk = 1'b1;
  always #12.5 i_ref_clk = ~i_ref_clk;
  initial begin
    i_link_clk = 1'b0;
    #2;
    forever #16 i_link_clk = ~i_link_clk;
  end
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == CYC_MAX) begin
      n_mismatch++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] lin(input logic [10:0] m);
    return {ptr_pkg::EXP_ZERO, m};
  endfunction
  task automatic rd(input logic [7:0] c, input logic blk, input logic [1:0] er,
                    input logic [15:0] ed, input logic [15:0] m);
    i_host.xfer(1'b0, blk, '{cmd: c, data: 16'h0000}, resp, rdat);
    chk_word({14'h0000, resp}, {14'h0000, er});
    if (er == 2'h1) chk_word(rdat & m, ed);
  endtask
  task automatic wr(input logic [7:0] c, input logic blk, input logic [15:0] d,
                    input logic [1:0] er);
    i_host.xfer(1'b1, blk, '{cmd: c, data: d}, resp, rdat);
    chk_word({14'h0000, resp}, {14'h0000, er});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic clr();
    step(1);
    i_clear_faults = 1'b1;
    step(1);
    i_clear_faults = 1'b0;
  endtask
  function automatic logic outsel(input int s);
    case (s)
      0: return o_status_iout;
      1: return o_output_enable;
      2: return o_nv_store_pulse;
      3: return o_invalid_data;
      default: return o_alert_line_n;
    endcase
  endfunction
  task automatic wait_out(input int s, input logic val, input int lim);
    int k;
    for (k = 0; k < lim && outsel(s) !== val; k++) begin
      @(posedge i_ref_clk);
      #1;
    end
    chk_bit(outsel(s), val);
  endtask
  task automatic fault(input logic [7:0] cfg);
    wr(ptr_pkg::CMD_AVG_OC_RESP, 1'b0, {8'h00, cfg}, 2'h1);
    step(1);
    i_avg_oc_event = 1'b1;
    step(1);
    i_avg_oc_event = 1'b0;
    wait_out(0, 1'b1, 10);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 87;
    {i_nrst, i_avg_oc_event, i_current_limiting, i_output_undervoltage_event} = 4'h0;
    {i_enable_off, i_clear_faults, i_store_all, i_other_fault_off} = 4'h0;
    i_regulating = 1'b1;
    i_temp_c = 11'h000;
    i_freq_khz = 11'h000;
    ids = '{ptr_pkg::CMD_MAKER_ID, ptr_pkg::CMD_MODEL, ptr_pkg::CMD_MAKER_REV,
            ptr_pkg::CMD_SERIAL};
    repeat (4) @(posedge i_ref_clk);
    #1;
    i_nrst = 1'b1;
    chk_bit(o_alert_line_n, 1'b1);
    rd(ptr_pkg::CMD_PROTO_REV, 1'b0, 2'h1, 16'h0033, 16'h00FF);
    wr(ptr_pkg::CMD_PROTO_REV, 1'b0, 16'h0044, 2'h2);
    rd(ptr_pkg::CMD_AVG_OC_RESP, 1'b0, 2'h1, 16'h0080, 16'h00FF);
    rd(ptr_pkg::CMD_VOUT_MIN, 1'b0, 2'h1, 16'h0100, 16'hFFFF);
    wr(ptr_pkg::CMD_VOUT_MIN, 1'b0, 16'h0200, 2'h2);
    rd(ptr_pkg::CMD_VOUT_MAX, 1'b0, 2'h1, 16'h0B01, 16'hFFFF);
    rd(ptr_pkg::CMD_CHIP_ID, 1'b1, 2'h1, {ptr_pkg::CHIP_ID_VAL, 8'h01}, 16'hFFFF);
    rd(ptr_pkg::CMD_CHIP_REV, 1'b1, 2'h1, {ptr_pkg::CHIP_REV_VAL, 8'h01}, 16'hFFFF);
    rd(ptr_pkg::CMD_CHIP_ID, 1'b0, 2'h2, 16'h0000, 16'h0000);
    wr(ptr_pkg::CMD_CHIP_REV, 1'b1, 16'h0701, 2'h2);
    rd(8'hC5, 1'b0, 2'h2, 16'h0000, 16'h0000);
    for (i = 0; i < 9; i++) begin
      t = ((($random(seed) % 216) + 216) % 216) - 40;
      if (i < 3) t = (i == 0) ? -40 : (i == 1) ? 175 : -20;
      i_temp_c = t[10:0];
      step(2);
      rd(ptr_pkg::CMD_TEMPERATURE, 1'b0, 2'h1, lin(t[10:0]), 16'hFFFF);
      t = ((($random(seed) % 1948) + 1948) % 1948) + 100;
      i_freq_khz = t[10:0];
      step(2);
      rd(ptr_pkg::CMD_SW_FREQ, 1'b0, 2'h1, lin(t[10:0]), 16'hFFFF);
    end
    i_regulating = 1'b0;
    step(2);
    rd(ptr_pkg::CMD_SW_FREQ, 1'b0, 2'h2, 16'h0000, 16'h0000);
    i_regulating = 1'b1;
    for (i = 0; i < 4; i++) begin
      v[i] = $random(seed);
      wr(ids[i], 1'b1, i_host.blk_word(v[i]), 2'h1);
      wr(ids[i], 1'b1, {~v[i], 8'h02}, 2'h2);
      wr(ids[i], 1'b0, i_host.blk_word(~v[i]), 2'h2);
      rd(ids[i], 1'b1, 2'h1, {v[i], 8'h01}, 16'hFFFF);
      rd(ids[i], 1'b0, 2'h2, 16'h0000, 16'h0000);
    end
    wr(ptr_pkg::CMD_AVG_OC_RESP, 1'b0, 16'h00BD, 2'h1);
    step(1);
    i_store_all = 1'b1;
    step(1);
    i_store_all = 1'b0;
    wait_out(2, 1'b1, 4);
    chk_word(o_nv_id_bytes[31:16], {v[0], v[1]});
    chk_word(o_nv_id_bytes[15:0], {v[2], v[3]});
    chk_word({8'h00, o_nv_avg_oc_cfg}, 16'h00BD);
    fault(8'h00);
    chk_bit(o_status_none_above, 1'b1);
    chk_bit(o_vendor_fault_summary_byte[7], 1'b1);
    chk_bit(o_alert_line_n, 1'b0);
    step(300);
    chk_bit(o_status_iout, 1'b1);
    chk_bit(o_output_enable, 1'b1);
    clr();
    wait_out(0, 1'b0, 10);
    wait_out(4, 1'b1, 10);
    fault(8'h40);
    step(20);
    chk_bit(o_output_enable, 1'b1);
    i_output_undervoltage_event = 1'b1;
    wait_out(1, 1'b0, 10);
    i_output_undervoltage_event = 1'b0;
    clr();
    wait_out(1, 1'b1, 10);
    fault(8'hC0);
    wait_out(1, 1'b0, 10);
    step(400);
    chk_bit(o_output_enable, 1'b0);
    clr();
    wait_out(1, 1'b1, 10);
    fault(8'hF8);
    wait_out(1, 1'b0, 10);
    wait_out(1, 1'b1, 260);
    // Shut down again, then hold it off by the enable, then by another fault
    for (i = 0; i < 2; i++) begin
      fault(8'hF8);
      wait_out(1, 1'b0, 10);
      {i_other_fault_off, i_enable_off} = 2'h1 << i;
      step(400);
      chk_bit(o_output_enable, 1'b0);
      {i_other_fault_off, i_enable_off} = 2'h0;
      wait_out(1, 1'b1, 260);
    end
    clr();
    i_current_limiting = 1'b1;
    fault(8'h80);
    step(6300);
    chk_bit(o_output_enable, 1'b1);
    wait_out(1, 1'b0, 200);
    i_current_limiting = 1'b0;
    clr();
    wait_out(1, 1'b1, 10);
    for (code = 1; code < 7; code++) begin
      wr(ptr_pkg::CMD_AVG_OC_RESP, 1'b0, {10'h003, code[2:0], 3'h0}, 2'h1);
      wait_out(3, 1'b1, 10);
      chk_bit(o_alert_line_n, 1'b0);
      rd(ptr_pkg::CMD_AVG_OC_RESP, 1'b0, 2'h1, 16'h0080, 16'h00FF);
      clr();
      wait_out(3, 1'b0, 10);
    end
    end_sim();
  end
endmodule // test_ptr_regs
